// *** hdl/cpfsm_pkg.sv ***
// Package for the cell protection state machine: register map, field positions,
// reset values, timing constants and the protection mode enumeration.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package cpfsm_pkg;

  // Clock rate in Hz.
  localparam int unsigned CLK_HZ            = 20_000_000;

  // Delay times in their own units, as typical figures.
  localparam int unsigned OV_DETECT_MS      = 1000;
  localparam int unsigned UV_DETECT_MS      = 1000;
  localparam int unsigned UV_RELEASE_MS     = 7;
  localparam int unsigned SAMPLE_ON_MS      = 2;
  localparam int unsigned SAMPLE_PERIOD_MS  = 125;

  // Shared timing source: one tick per millisecond.
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000;

  // Register byte offsets.
  localparam logic [7:0] CONTROL_OFS        = 8'h00;
  localparam logic [7:0] CONFIG_OFS         = 8'h04;
  localparam logic [7:0] STATUS_OFS         = 8'h08;
  localparam logic [7:0] CELLS_OFS          = 8'h0c;

  // Control register fields.
  localparam int unsigned CHG_CTL_BIT       = 0;
  localparam int unsigned DSG_CTL_BIT       = 1;
  localparam int unsigned MONITOR_BIT       = 2;
  localparam logic [2:0]  CONTROL_RESET     = 3'h3;

  // Configuration register fields.
  localparam int unsigned UV_LSB_BIT        = 0;
  localparam int unsigned UV_MSB_BIT        = 1;
  localparam logic [1:0]  CONFIG_RESET      = 2'h0;

  // Status register fields.
  localparam int unsigned STAT_OV_BIT       = 0;
  localparam int unsigned STAT_UV_BIT       = 1;
  localparam int unsigned STAT_CHG_BIT      = 2;
  localparam int unsigned STAT_DSG_BIT      = 3;

  // AXI responses.
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Protection modes.
  typedef enum logic [1:0] {
    CPFSM_NORMAL,
    CPFSM_OV_PROTECT,
    CPFSM_UV_SLEEP,
    CPFSM_UV_RECOVER
  } cpfsm_mode_t;

endpackage : cpfsm_pkg

// *** hdl/cpfsm_top.sv ***
// Cell protection state machine with an AXI4-Lite register slave.
// Assumes comparator outputs arrive asynchronously from the analog front end,
// one bit per cell, and that the host follows the over-discharge recovery steps.
// Contract
// - Cell above over-charge level starts detect timer; stay normal meanwhile.
// - Over-charge detect timer runs the full configured delay; here it stops early once no cell is above during a sample window.
// - At expiry, enter over-charge protection only if a cell still high.
// - Entering over-charge protection turns charge gate off, discharge untouched.
// - In over-charge protection keep checking all cells against release level.
// - Over-charge protection never forces the discharge gate off.
// - Host control writes are accepted during over-charge protection.
// - All cells below release level: return normal, charge gate on automatically.
// - Leaving over-charge protection leaves discharge gate unchanged.
// - Cell low past detect delay turns discharge gate off, then sleep.
// - Over-discharge level chosen by two-bit config field via config write.
// - After sleep, no discharge until wake and all recovery steps in order.
// - All cells above release level for the release delay in total before recovery; count restarts only when no cell is above.
// - Both over-discharge delays derive from one shared millisecond tick.
// - Charge bit written during protection is stored, but release sets it to one.
// - In low-power operation comparisons enabled only in short sample window.
// - Status bit one reads one only in over-discharge protection.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
module cpfsm_top
  import cpfsm_pkg::*;
#(
  parameter int unsigned NUM_CELLS   = 4,
  parameter int unsigned TICK_CYC    = TICK_CYCLES,
  parameter int unsigned OV_DLY_MS   = OV_DETECT_MS,
  parameter int unsigned UV_DLY_MS   = UV_DETECT_MS,
  parameter int unsigned UVR_DLY_MS  = UV_RELEASE_MS
) (
  // Clock and reset.
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Comparator results, one bit per cell.
  input  wire logic [NUM_CELLS-1:0] cell_above_ov,
  input  wire logic [NUM_CELLS-1:0] cell_below_ovr,
  input  wire logic [NUM_CELLS-1:0] cell_below_uv,
  input  wire logic [NUM_CELLS-1:0] cell_above_uvr,
  // Wake from sleep, asynchronous level.
  input  wire logic                 wake_in,
  // Gate drives, high turns the FET off.
  output logic                      charge_gate_out,
  output logic                      discharge_gate_out,
  // Threshold selection and comparator enable toward the analog side.
  output logic                      undervolt_level_msb,
  output logic                      undervolt_level_lsb,
  output logic                      compare_enable
);

  localparam int unsigned NSYNC = 4 * NUM_CELLS + 1;

  // Two-flop synchroniser for every asynchronous input.
  logic [NSYNC-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  always_comb begin
    sync1_next = {wake_in, cell_above_uvr, cell_below_uv, cell_below_ovr, cell_above_ov};
    sync2_next = sync1_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic [NUM_CELLS-1:0] above_ov, below_ovr, below_uv, above_uvr;
  logic                 wake_s;
  assign above_ov  = sync2_reg[NUM_CELLS-1:0];
  assign below_ovr = sync2_reg[2*NUM_CELLS-1:NUM_CELLS];
  assign below_uv  = sync2_reg[3*NUM_CELLS-1:2*NUM_CELLS];
  assign above_uvr = sync2_reg[4*NUM_CELLS-1:3*NUM_CELLS];
  assign wake_s    = sync2_reg[NSYNC-1];

  // Shared millisecond tick and sample window counters.
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [7:0]  win_cnt_reg, win_cnt_next;
  logic        tick;
  logic [2:0]  ctl_reg, ctl_next;
  logic        window_on;
  assign tick      = (tick_cnt_reg == 32'(TICK_CYC - 1));
  assign window_on = (win_cnt_reg < 8'(SAMPLE_ON_MS)) | ctl_reg[MONITOR_BIT];
  always_comb begin
    tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
    win_cnt_next  = win_cnt_reg;
    if (tick) begin
      win_cnt_next = (win_cnt_reg == 8'(SAMPLE_PERIOD_MS - 1)) ? 8'h0 : win_cnt_reg + 8'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= '0;
      win_cnt_reg  <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      win_cnt_reg  <= win_cnt_next;
    end
  end

  // Comparator views gated by the sample window.
  logic any_ov, all_ovr, any_uv, all_uvr;
  assign any_ov  = window_on & (|above_ov);
  assign all_ovr = window_on & (&below_ovr);
  assign any_uv  = window_on & (|below_uv);
  assign all_uvr = window_on & (&above_uvr);

  // Write channel capture and register write decode.
  logic       aw_held_reg, aw_held_next, w_held_reg, w_held_next, bvalid_reg, bvalid_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic       wstrb0_reg, wstrb0_next;
  logic [1:0] bresp_reg, bresp_next;
  logic [1:0] cfg_reg, cfg_next;
  logic       do_write, wr_ctl;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_ctl   = do_write & wstrb0_reg & (awaddr_reg == CONTROL_OFS);
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    cfg_next     = cfg_reg;
    if (s_axi_awvalid & s_axi_awready) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb0_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      case (awaddr_reg)
        CONTROL_OFS: ;
        CONFIG_OFS: begin
          if (wstrb0_reg) cfg_next = wdata_reg[UV_MSB_BIT:UV_LSB_BIT];
        end
        STATUS_OFS, CELLS_OFS: ;
        default: bresp_next = RESP_SLVERR;
      endcase
    end else if (bvalid_reg & s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      cfg_reg     <= CONFIG_RESET;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb0_reg  <= wstrb0_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      cfg_reg     <= cfg_next;
    end
  end

  // Protection state machine, delay timer and gate drives.
  cpfsm_mode_t mode_reg, mode_next;
  logic [15:0] dly_reg, dly_next;
  logic        ov_run_reg, ov_run_next, uv_run_reg, uv_run_next;
  logic        chg_off_reg, chg_off_next, dsg_off_reg, dsg_off_next;
  logic        chg_ok_reg, chg_ok_next;
  always_comb begin
    mode_next    = mode_reg;
    dly_next     = dly_reg;
    ov_run_next  = ov_run_reg;
    uv_run_next  = uv_run_reg;
    ctl_next     = ctl_reg;
    chg_off_next = chg_off_reg;
    dsg_off_next = dsg_off_reg;
    chg_ok_next  = chg_ok_reg;
    // Host control writes are stored here; sleep clears them and recovery may clear the discharge bit.
    if (wr_ctl) ctl_next = wdata_reg[2:0];
    case (mode_reg)
      CPFSM_NORMAL: begin
        // Host bits drive the gates directly in normal mode.
        chg_off_next = ~ctl_next[CHG_CTL_BIT];
        dsg_off_next = ~ctl_next[DSG_CTL_BIT];
        if (uv_run_reg) begin
          if (!(|below_uv) && window_on) begin
            uv_run_next = 1'b0;
          end else if (tick) begin
            if (dly_reg == 16'(UV_DLY_MS - 1)) begin
              uv_run_next  = 1'b0;
              if (any_uv) begin
                dsg_off_next = 1'b1;
                chg_off_next = 1'b1;
                ctl_next     = '0;
                chg_ok_next  = 1'b0;
                mode_next    = CPFSM_UV_SLEEP;
              end
            end else dly_next = dly_reg + 16'h1;
          end
        end else if (ov_run_reg) begin
          if (!(|above_ov) && window_on) begin
            ov_run_next = 1'b0;
          end else if (tick) begin
            if (dly_reg == 16'(OV_DLY_MS - 1)) begin
              ov_run_next = 1'b0;
              if (any_ov) begin
                chg_off_next = 1'b1;
                mode_next    = CPFSM_OV_PROTECT;
              end
            end else dly_next = dly_reg + 16'h1;
          end
        end else if (any_uv) begin
          uv_run_next = 1'b1;
          dly_next    = '0;
        end else if (any_ov) begin
          ov_run_next = 1'b1;
          dly_next    = '0;
        end
      end
      CPFSM_OV_PROTECT: begin
        // Charge stays off; the discharge gate follows the host only.
        chg_off_next = 1'b1;
        dsg_off_next = ~ctl_next[DSG_CTL_BIT];
        if (all_ovr) begin
          mode_next    = CPFSM_NORMAL;
          chg_off_next = 1'b0;
          ctl_next[CHG_CTL_BIT] = 1'b1;
        end
      end
      CPFSM_UV_SLEEP: begin
        chg_off_next = 1'b1;
        dsg_off_next = 1'b1;
        ctl_next     = '0;
        if (wake_s) begin
          mode_next = CPFSM_UV_RECOVER;
          dly_next  = '0;
        end
      end
      CPFSM_UV_RECOVER: begin
        chg_off_next = ~ctl_next[CHG_CTL_BIT];
        dsg_off_next = 1'b1;
        if (!(|above_uvr) && window_on) begin
          dly_next = '0;
        end else if (tick && all_uvr && dly_reg != 16'(UVR_DLY_MS)) begin
          dly_next = dly_reg + 16'h1;
        end
        if (ctl_next[CHG_CTL_BIT]) chg_ok_next = 1'b1;
        if (chg_ok_reg && dly_reg == 16'(UVR_DLY_MS) && wr_ctl && ctl_next[DSG_CTL_BIT]) begin
          dsg_off_next = 1'b0;
          mode_next    = CPFSM_NORMAL;
        end else if (!(chg_ok_reg && dly_reg == 16'(UVR_DLY_MS))) begin
          ctl_next[DSG_CTL_BIT] = 1'b0;
        end
      end
      default: mode_next = CPFSM_NORMAL;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg    <= CPFSM_NORMAL;
      dly_reg     <= '0;
      ov_run_reg  <= 1'b0;
      uv_run_reg  <= 1'b0;
      ctl_reg     <= CONTROL_RESET;
      chg_off_reg <= 1'b0;
      dsg_off_reg <= 1'b0;
      chg_ok_reg  <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      dly_reg     <= dly_next;
      ov_run_reg  <= ov_run_next;
      uv_run_reg  <= uv_run_next;
      ctl_reg     <= ctl_next;
      chg_off_reg <= chg_off_next;
      dsg_off_reg <= dsg_off_next;
      chg_ok_reg  <= chg_ok_next;
    end
  end

  // Read channel: one-cycle answer from registered data.
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        win_reg, win_next;
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    win_next    = window_on;
    if (s_axi_arvalid & ~rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = '0;
      rresp_next  = RESP_OKAY;
      case (s_axi_araddr)
        CONTROL_OFS: rdata_next[2:0] = ctl_reg;
        CONFIG_OFS:  rdata_next[UV_MSB_BIT:UV_LSB_BIT] = cfg_reg;
        STATUS_OFS: begin
          rdata_next[STAT_OV_BIT]  = (mode_reg == CPFSM_OV_PROTECT);
          rdata_next[STAT_UV_BIT]  = (mode_reg == CPFSM_UV_SLEEP) |
                                     (mode_reg == CPFSM_UV_RECOVER);
          rdata_next[STAT_CHG_BIT] = chg_off_reg;
          rdata_next[STAT_DSG_BIT] = dsg_off_reg;
        end
        CELLS_OFS: rdata_next[NUM_CELLS-1:0] = above_ov;
        default: rresp_next = RESP_SLVERR;
      endcase
    end else if (rvalid_reg & s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
      win_reg    <= 1'b0;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
      win_reg    <= win_next;
    end
  end

  // Output drives, all from flip-flops.
  assign s_axi_awready       = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready        = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = ~rvalid_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign charge_gate_out     = chg_off_reg;
  assign discharge_gate_out  = dsg_off_reg;
  assign undervolt_level_msb = cfg_reg[1];
  assign undervolt_level_lsb = cfg_reg[0];
  assign compare_enable      = win_reg;

endmodule // cpfsm_top

// *** verif/cell_protection_fsm_tb.sv ***
// Self-checking bench for the cell protection state machine.
// Assumes shortened delays: 4-cycle tick, detect 5 ticks, release 3 ticks.
module cell_protection_fsm_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpfsm_pkg::*;
  localparam int NC = 4, TK = 4, OVD = 5, UVD = 5, UVRD = 3;
  logic             aclk = 1'b0, aresetn = 1'b0, wake_in = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]       s_axi_wstrb = 4'hf;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp, rsp;
  logic [NC-1:0]    cell_above_ov, cell_below_ovr, cell_below_uv, cell_above_uvr;
  logic             charge_gate_out, discharge_gate_out, compare_enable;
  logic             undervolt_level_msb, undervolt_level_lsb;
  logic [3*NC-1:0]  lvl = {NC{3'h2}};
  int               err_count = 0, compares = 0, k;

  cpfsm_top #(.NUM_CELLS(NC), .TICK_CYC(TK), .OV_DLY_MS(OVD), .UV_DLY_MS(UVD),
    .UVR_DLY_MS(UVRD)) dut_u (.*);
  cpfsm_cells #(.NUM_CELLS(NC)) cells_u (.aclk(aclk), .cell_level(lvl),
    .compare_enable(compare_enable), .cell_above_ov(cell_above_ov),
    .cell_below_ovr(cell_below_ovr), .cell_below_uv(cell_below_uv),
    .cell_above_uvr(cell_above_uvr));

  // Clock.
  initial forever #25 aclk = ~aclk;

  // Expected detect windows in cycles.
  function automatic int lo_of(input int d); return (d - 1) * TK; endfunction
  function automatic int hi_of(input int d); return (d + 1) * TK + 8; endfunction

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic fail_to();
    err_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Bus write; the response code lands in rsp.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 64 && !hb; n++) begin
      #1;
      ha = s_axi_awvalid && s_axi_awready === 1'b1;
      hw = s_axi_wvalid && s_axi_wready === 1'b1;
      hb = s_axi_bvalid === 1'b1;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
    if (!hb) fail_to();
  endtask
  // Bus read into rd and rsp.
  task automatic rd_reg(input logic [7:0] a);
    logic ha, hr;
    hr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 64 && !hr; n++) begin
      #1;
      ha = s_axi_arvalid && s_axi_arready === 1'b1;
      hr = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
    if (!hr) fail_to();
  endtask
  // Waits for a gate level and checks how long it took.
  task automatic wait_gate(input logic dsg, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (n <= hi && (dsg ? discharge_gate_out : charge_gate_out) !== v) begin
      @(posedge aclk);
      #1;
      n++;
    end
    if (n > hi) fail_to();
    chk(32'(n >= lo), 32'h1, "gate changed too early");
  endtask
  // Checks that both gates keep the given levels for n cycles.
  task automatic hold(input logic c, input logic d, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge aclk);
      #1;
      ok &= charge_gate_out === c && discharge_gate_out === d;
    end
    chk(32'(ok), 32'h1, "gates moved");
  endtask
  task automatic setc(input int c, input logic [2:0] v);
    @(posedge aclk);
    lvl[3*c+:3] <= v;
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'h8e41));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(CONTROL_OFS);
    chk(rd, {29'h0, CONTROL_RESET}, "control reset");
    rd_reg(CONFIG_OFS);
    chk(rd, {30'h0, CONFIG_RESET}, "config reset");
    rd_reg(STATUS_OFS);
    chk(rd, 32'h0, "status reset");
    rd_reg(8'h10);
    chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h10, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    k = 0;
    repeat (2 * SAMPLE_PERIOD_MS * TK) begin
      @(posedge aclk);
      #1;
      k += int'(compare_enable === 1'b1);
    end
    chk(32'(k >= (2 * SAMPLE_ON_MS - 1) * TK && k <= (2 * SAMPLE_ON_MS + 1) * TK), 32'h1, "window");
    wr(CONTROL_OFS, 32'h7);
    hold(1'b0, 1'b0, 3);
    chk({31'h0, compare_enable}, 32'h1, "monitor");
    for (int i = 0; i < 4; i++) begin
      rd = $urandom();
      rd[1:0] = 2'(i);
      wr(CONFIG_OFS, rd);
      hold(1'b0, 1'b0, 2);
      chk({30'h0, undervolt_level_msb, undervolt_level_lsb}, 32'(i), "level pins");
      rd_reg(CONFIG_OFS);
      chk({30'h0, rd[1:0]}, 32'(i), "level readback");
    end
    $display("test registers done");
    k = $urandom_range(NC - 1);
    setc(k, 3'h4);
    hold(1'b0, 1'b0, lo_of(OVD) - TK);
    setc(k, 3'h2);
    hold(1'b0, 1'b0, hi_of(OVD));
    setc(k, 3'h4);
    wait_gate(1'b0, 1'b1, lo_of(OVD), hi_of(OVD));
    rd_reg(STATUS_OFS);
    chk({28'h0, rd[3:0]}, 32'h5, "ov status");
    setc(k, 3'h3);
    hold(1'b1, 1'b0, 4 * TK);
    wr(CONTROL_OFS, 32'h5);
    wait_gate(1'b1, 1'b1, 0, 8);
    wr(CONTROL_OFS, 32'h7);
    wait_gate(1'b1, 1'b0, 0, 8);
    wr(CONTROL_OFS, 32'h6);
    rd_reg(CONTROL_OFS);
    chk({31'h0, rd[0]}, 32'h0, "charge bit stored");
    hold(1'b1, 1'b0, 4);
    setc(k, 3'h2);
    wait_gate(1'b0, 1'b0, 0, hi_of(1));
    hold(1'b0, 1'b0, 2);
    rd_reg(CONTROL_OFS);
    chk({31'h0, rd[0]}, 32'h1, "charge bit on release");
    $display("test over-charge done");
    setc(k, 3'h0);
    wait_gate(1'b1, 1'b1, lo_of(UVD), hi_of(UVD));
    rd_reg(STATUS_OFS);
    chk({28'h0, rd[3:0]}, 32'he, "sleep status");
    rd_reg(CONTROL_OFS);
    chk({29'h0, rd[2:0]}, 32'h0, "control cleared");
    wr(CONTROL_OFS, 32'h2);
    hold(1'b1, 1'b1, 4 * TK);
    setc(k, 3'h1);
    wake_in <= 1'b1;
    hold(1'b1, 1'b1, 4);
    wr(CONTROL_OFS, 32'h5);
    wait_gate(1'b0, 1'b0, 0, 8);
    wr(CONTROL_OFS, 32'h7);
    hold(1'b0, 1'b1, (UVRD + 2) * TK);
    rd_reg(CONTROL_OFS);
    chk({31'h0, rd[1]}, 32'h0, "early discharge write");
    setc(k, 3'h2);
    hold(1'b0, 1'b1, (UVRD + 2) * TK);
    wr(CONTROL_OFS, 32'h7);
    wait_gate(1'b1, 1'b0, 0, 8);
    rd_reg(STATUS_OFS);
    chk({28'h0, rd[3:0]}, 32'h0, "recovered status");
    wake_in <= 1'b0;
    $display("test over-discharge done");
    print_verdict();
  end
endmodule // cell_protection_fsm_tb

// *** verif/cpfsm_assertions.sv ***
// Concurrent checks on the ports of the cell protection state machine.
// Assumes a bench that writes the control register only through full bus cycles.
module cpfsm_checker
  import cpfsm_pkg::*;
#(
  parameter int unsigned NUM_CELLS = 4,
  parameter int unsigned TICK_CYC  = 4,
  parameter int unsigned OV_DLY_MS = 5,
  parameter int unsigned UV_DLY_MS = 5
) (
  // Clock and reset.
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Bus handshakes.
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata,
  // Cells and gates.
  input wire logic [NUM_CELLS-1:0] cell_above_ov,
  input wire logic [NUM_CELLS-1:0] cell_below_ovr,
  input wire logic [NUM_CELLS-1:0] cell_below_uv,
  input wire logic                 compare_enable,
  input wire logic                 charge_gate_out,
  input wire logic                 discharge_gate_out
);
  localparam int OVMIN = (OV_DLY_MS - 1) * TICK_CYC;
  localparam int UVMIN = (UV_DLY_MS - 1) * TICK_CYC;
  logic [3:0] wr_age_reg, wr_age_next, ovr_run_reg, ovr_run_next;
  int         ov_run_reg, ov_run_next, uv_run_reg, uv_run_next;

  // Age of the last host write and run lengths of the over-charge, release and over-discharge conditions.
  always_comb begin
    wr_age_next = wr_age_reg + {3'h0, wr_age_reg != 4'hf};
    if (s_axi_wvalid && s_axi_wready) wr_age_next = 4'h0;
    ov_run_next = (|cell_above_ov || !compare_enable) ? ov_run_reg + 1 : 0;
    uv_run_next = (|cell_below_uv || !compare_enable) ? uv_run_reg + 1 : 0;
    ovr_run_next = ovr_run_reg + {3'h0, ovr_run_reg != 4'hf};
    if (!(&cell_below_ovr) || !compare_enable) ovr_run_next = 4'h0;
  end

  // Helper registers.
  always_ff @(posedge aclk) begin
    wr_age_reg  <= aresetn ? wr_age_next : 4'h0;
    ovr_run_reg <= aresetn ? ovr_run_next : 4'h0;
    ov_run_reg  <= aresetn ? ov_run_next : 0;
    uv_run_reg  <= aresetn ? uv_run_next : 0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("Write response dropped early.");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("Read data dropped early.");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read accepted while answer pending.");
  ov_delay_a: assert property ($rose(charge_gate_out) && !discharge_gate_out
    && !(|cell_below_uv) && wr_age_reg == 4'hf |-> ov_run_reg >= OVMIN)
    else $error("Charge gate off before detect delay.");
  ov_release_a: assert property (ovr_run_reg == 4'h1 && charge_gate_out
    && !discharge_gate_out |-> ##[0:16] !charge_gate_out)
    else $error("Charge gate not restored on release.");
  dsg_steady_a: assert property (!discharge_gate_out && wr_age_reg == 4'hf
    && uv_run_reg < UVMIN |=> !discharge_gate_out)
    else $error("Discharge gate moved without cause.");
  uv_sleep_a: assert property ($rose(discharge_gate_out) && wr_age_reg == 4'hf
    |-> ##[0:2] charge_gate_out) else $error("Sleep left charge gate on.");
  dsg_host_a: assert property ($fell(discharge_gate_out) |-> wr_age_reg < 4'h8)
    else $error("Discharge gate on without host write.");
  chg_wake_a: assert property ($fell(charge_gate_out) && discharge_gate_out
    |-> wr_age_reg < 4'h8) else $error("Charge gate on in sleep without write.");

  ov_enter_c: cover property ($rose(charge_gate_out) && !discharge_gate_out);
  uv_enter_c: cover property ($rose(discharge_gate_out) && wr_age_reg == 4'hf);
  recover_c: cover property ($fell(discharge_gate_out));
endmodule // cpfsm_checker

bind cpfsm_top cpfsm_checker #(.NUM_CELLS(NUM_CELLS), .TICK_CYC(TICK_CYC),
  .OV_DLY_MS(OV_DLY_MS), .UV_DLY_MS(UV_DLY_MS)) chk_u (.*);

// *** verif/cpfsm_cells.sv ***
// Behavioural model of the battery cells and their comparators.
// Assumes a 3-bit level per cell: 0 deep low, 1 below release, 2 normal, 3 near full, 4 over.
module cpfsm_cells #(
  parameter int unsigned NUM_CELLS = 4
) (
  // Clock, levels and comparator enable.
  input wire logic                   aclk,
  input wire logic [3*NUM_CELLS-1:0] cell_level,
  input wire logic                   compare_enable,
  // Comparator results.
  output logic [NUM_CELLS-1:0]       cell_above_ov,
  output logic [NUM_CELLS-1:0]       cell_below_ovr,
  output logic [NUM_CELLS-1:0]       cell_below_uv,
  output logic [NUM_CELLS-1:0]       cell_above_uvr
);
  logic flip_reg = 1'b0;

  // Idle comparators show a pattern that changes every cycle.
  always_ff @(posedge aclk) flip_reg <= ~flip_reg;

  // Comparator outputs while enabled.
  always_comb begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      cell_below_uv[i]  = compare_enable ? cell_level[3*i+:3] == 3'h0 : flip_reg;
      cell_above_uvr[i] = compare_enable ? cell_level[3*i+:3] >= 3'h2 : ~flip_reg;
      cell_below_ovr[i] = compare_enable ? cell_level[3*i+:3] <= 3'h2 : ~flip_reg;
      cell_above_ov[i]  = compare_enable ? cell_level[3*i+:3] == 3'h4 : flip_reg;
    end
  end
endmodule // cpfsm_cells
